/* File: bench/mmd_bus_sva.sv */
// Checker on the shared bus between requester and decoder.
// Assumes instantiation beside the interface, signals joined by name.
`timescale 1ns/1ns
`default_nettype none
module mmd_bus_sva
  import mmd_pkg::*;
#(
  parameter int RAM_BYTES   = RAM_BYTES_DEF,
  parameter int FLASH_BYTES = FLASH_BYTES_DEF
) (
  input wire logic              clk_sys,            // Clock
  input wire logic              nrst,               // Reset
  input wire logic              req,                // Request
  input wire logic              fetch,              // Fetch
  input wire logic              we,                 // Write
  input wire logic              byte_en,            // Byte width
  input wire logic [ADDR_W-1:0] shared_address_bus, // Address
  input wire logic [DATA_W-1:0] shared_data_bus_wr, // Write data
  input wire logic [DATA_W-1:0] shared_data_bus_rd, // Read data
  input wire logic              ack,                // Answer
  input wire logic              err                 // Fault
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!nrst);
  logic unmapped;
  // Gap above RAM below flash, and all of the upper 64 KB
  assign unmapped = shared_address_bus[16] || (shared_address_bus >= RAM_LO + RAM_BYTES
                    && shared_address_bus < 17'h10000 - FLASH_BYTES);
  property p_ack_next; $rose(req) |=> ack; endproperty
  a_ack_next: assert property (p_ack_next) else $error("no ack after request");
  property p_ack_pulse; ack |=> !ack; endproperty
  a_ack_pulse: assert property (p_ack_pulse) else $error("ack too long");
  property p_req_hold; req && !ack |=> req && $stable(shared_address_bus); endproperty
  a_req_hold: assert property (p_req_hold) else $error("request dropped early");
  property p_fetch_even; req && fetch |-> !shared_address_bus[0]; endproperty
  a_fetch_even: assert property (p_fetch_even) else $error("odd fetch");
  property p_word_even; req && !byte_en |-> !shared_address_bus[0]; endproperty
  a_word_even: assert property (p_word_even) else $error("odd word access");
  property p_cfg_byte; req && shared_address_bus <= CFG_HI |-> byte_en; endproperty
  a_cfg_byte: assert property (p_cfg_byte) else $error("word to config bytes");
  property p_p16_even;
    req && byte_en && shared_address_bus inside {[PER16_LO:PER16_HI]} |-> !shared_address_bus[0];
  endproperty
  a_p16_even: assert property (p_p16_even) else $error("odd byte to 16-bit module");
  property p_unmapped_zero; ack && !we && unmapped |-> shared_data_bus_rd == ZERO_WORD; endproperty
  a_unmapped_zero: assert property (p_unmapped_zero) else $error("unmapped read nonzero");
  property p_byte_high_zero; ack && !we && byte_en |-> shared_data_bus_rd[15:8] == 8'h00; endproperty
  a_byte_high_zero: assert property (p_byte_high_zero) else $error("byte read high set");
  property p_wdata_hold;
    req && !ack |=> $stable(shared_data_bus_wr) && $stable(we);
  endproperty
  a_wdata_hold: assert property (p_wdata_hold) else $error("write data moved early");
  property p_no_fault; ack |-> !err; endproperty
  a_no_fault: assert property (p_no_fault) else $error("width rule broken");
endmodule
`default_nettype wire

/* File: bench/tb_memory_map_access_decoder.sv */
// Testbench: requester and decoder joined by the bus interface.
// Assumes flash reads back blank, since nothing in this bench loads it.
`timescale 1ns/1ns
`default_nettype none
module tb_memory_map_access_decoder;
  import mmd_pkg::*;
  logic              clk_sys = 1'b0;
  logic              nrst;
  logic              cmd_valid = 1'b0, cmd_fetch = 1'b0, cmd_we = 1'b0, cmd_byte = 1'b0;
  logic [ADDR_W-1:0] cmd_addr = 17'h0;
  logic [DATA_W-1:0] cmd_wdata = 16'h0, per_rdata = 16'h0, rdata, per_wdata, r, wd_seen;
  logic              cmd_ready, done, rerr, vec_hit, cfg_sel, p8_sel, p16_sel, per_we;
  logic [7:0]        per_addr;
  logic [1:0]        per_be, be_seen;
  logic [3:0]        sel_seen;
  logic [8:0]        pa_seen;
  int                num_errors = 0, total_checks = 0;
  always #5 clk_sys = ~clk_sys;
  mmd_bus_if mmd_bus_if_i ();
  mmd_decoder mmd_decoder_i (.clk_sys, .nrst, .bus(mmd_bus_if_i), .vec_hit, .cfg_sel, .p8_sel,
    .p16_sel, .per_we, .per_addr, .per_wdata, .per_be, .per_rdata);
  mmd_requester mmd_requester_i (.clk_sys, .nrst, .bus(mmd_bus_if_i), .cmd_valid, .cmd_fetch,
    .cmd_we, .cmd_byte, .cmd_addr, .cmd_wdata, .cmd_ready, .done, .rdata, .rerr);
  mmd_bus_sva mmd_bus_sva_i (.clk_sys, .nrst, .req(mmd_bus_if_i.req), .fetch(mmd_bus_if_i.fetch),
    .we(mmd_bus_if_i.we), .byte_en(mmd_bus_if_i.byte_en), .ack(mmd_bus_if_i.ack),
    .shared_address_bus(mmd_bus_if_i.shared_address_bus), .err(mmd_bus_if_i.err),
    .shared_data_bus_wr(mmd_bus_if_i.shared_data_bus_wr),
    .shared_data_bus_rd(mmd_bus_if_i.shared_data_bus_rd));
  // Strobes are only meaningful in the take cycle
  always @(posedge clk_sys)
    if (mmd_bus_if_i.req && !mmd_bus_if_i.ack) begin
      sel_seen <= {vec_hit, cfg_sel, p8_sel, p16_sel};
      pa_seen  <= {per_we, per_addr};
      wd_seen  <= per_wdata;
      be_seen  <= per_be;
    end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic end_of_test();
    $display("Checks %0d, mismatches %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic acc(input logic f, w, b, input logic [16:0] a, input logic [15:0] d);
    int n;
    @(posedge clk_sys);
    cmd_valid <= 1'b1;
    cmd_fetch <= f;
    cmd_we <= w;
    cmd_byte <= b;
    cmd_addr <= a;
    cmd_wdata <= d;
    @(posedge clk_sys);
    cmd_valid <= 1'b0;
    n = 0;
    do begin
      @(posedge clk_sys);
      #1;
      n++;
    end while (done !== 1'b1 && n < 20);
    if (done !== 1'b1) begin
      num_errors++;
      end_of_test();
    end else begin
      r = rdata;
    end
  endtask
  task automatic t_ram();
    acc(0, 1, 0, 17'h00204, 16'ha55a);
    acc(0, 0, 1, 17'h00205, 16'h0);
    chk(r, 16'h00a5);
    acc(0, 1, 1, 17'h00204, 16'h3c3c);
    acc(0, 0, 0, 17'h00205, 16'h0);
    chk(r, 16'ha53c);
    acc(1, 0, 0, 17'h00204, 16'h0);
    chk(r, 16'ha53c);
    acc(0, 1, 0, 17'h009fe, 16'h1234);
    acc(0, 0, 0, 17'h009fe, 16'h0);
    chk(r, 16'h1234);
    $display("t_ram finished");
  endtask
  task automatic t_per();
    @(posedge clk_sys);
    per_rdata <= 16'hbeef;
    acc(0, 0, 0, 17'h00020, 16'h0);
    chk(r[7:0], 8'hef);
    chk(sel_seen, 4'b0010);
    acc(0, 1, 0, 17'h00020, 16'h1234);
    chk(wd_seen, 16'h0034);
    chk(be_seen, 2'b01);
    chk(pa_seen, 9'h120);
    acc(0, 0, 1, 17'h000ff, 16'h0);
    chk(sel_seen, 4'b0010);
    acc(0, 0, 0, 17'h001fe, 16'h0);
    chk(r, 16'hbeef);
    chk(sel_seen, 4'b0001);
    chk(pa_seen, 9'h0fe);
    chk(be_seen, 2'b11);
    acc(0, 0, 1, 17'h00100, 16'h0);
    chk(r, 16'h00ef);
    chk(be_seen, 2'b01);
    acc(0, 0, 1, 17'h0000f, 16'h0);
    chk(sel_seen, 4'b0100);
    chk(r[15:8], 8'h00);
    $display("t_per finished");
  endtask
  task automatic t_map();
    acc(0, 1, 0, 17'h01000, 16'hffff);
    acc(0, 0, 0, 17'h01000, 16'h0);
    chk(r, 16'h0);
    chk(sel_seen, 4'b0000);
    acc(0, 0, 0, 17'h1fffe, 16'h0);
    chk(r, 16'h0);
    acc(1, 0, 0, 17'h0fffe, 16'h0);
    chk(sel_seen[3], 1'b1);
    chk(rerr, 1'b0);
    chk(r, FLASH_BLANK);
    acc(1, 0, 0, 17'h0ffe0, 16'h0);
    chk(sel_seen[3], 1'b1);
    acc(1, 0, 0, 17'h0ffde, 16'h0);
    chk(sel_seen[3], 1'b0);
    acc(1, 0, 0, 17'h08000, 16'h0);
    chk(r, FLASH_BLANK);
    chk(sel_seen, 4'b0000);
    acc(0, 0, 0, 17'h07ffe, 16'h0);
    chk(r, 16'h0);
    $display("t_map finished");
  endtask
  task automatic t_reset();
    @(posedge clk_sys);
    nrst <= 1'b0;
    repeat (2) @(posedge clk_sys);
    #1;
    chk(cmd_ready, 1'b1);
    chk(mmd_bus_if_i.ack, 1'b0);
    @(posedge clk_sys);
    nrst <= 1'b1;
    $display("t_reset finished");
  endtask
  initial begin
    nrst <= 1'b0;
    repeat (4) @(posedge clk_sys);
    nrst <= 1'b1;
    t_ram();
    t_per();
    t_map();
    t_reset();
    t_ram();
    end_of_test();
  end
endmodule
`default_nettype wire

/* File: rtl/mmd_bus_if.sv */
// Interface joining the CPU-side requester and the address decoder.
// Single clock domain; one request outstanding at a time.
`timescale 1ns/1ns
`default_nettype none
interface mmd_bus_if;
  import mmd_pkg::*;
  logic              req;       // Request valid
  logic              fetch;     // Instruction fetch
  logic              we;        // Write
  logic              byte_en;   // Byte width when high, word when low
  logic [ADDR_W-1:0] shared_address_bus;
  logic [DATA_W-1:0] shared_data_bus_wr;
  logic [DATA_W-1:0] shared_data_bus_rd;
  logic              ack;       // Access complete
  logic              err;       // Access broke a width rule

  modport dev (input req, fetch, we, byte_en, shared_address_bus, shared_data_bus_wr,
               output shared_data_bus_rd, ack, err);
  modport cpu (output req, fetch, we, byte_en, shared_address_bus, shared_data_bus_wr,
               input shared_data_bus_rd, ack, err);
endinterface
`default_nettype wire

/* File: rtl/mmd_decoder.sv */
// Address decoder and width adapter on the shared 16-bit bus.
// Assumes one request at a time held until ack; memories answer in one cycle.
// Notes on behaviour
// - One shared bus: 17-bit address, 16-bit data
// - All regions decoded in one address space
// - Requester fetches instructions at even addresses
// - Byte and word data accesses supported
// - Address space covers 128 KB
// - Flash ends at 0FFFFh, start by size
// - Vector table is top 16 flash words
// - RAM from 0200h, fetch and data
// - 0100h-01FFh is 16-bit peripheral region
// - 16-bit peripheral byte read: even, high zero
// - 010h-0FFh is 8-bit peripheral region
// - Word read of 8-bit peripheral: low valid
// - Word write to 8-bit peripheral: low only
// - Config regs lowest 16 bytes, byte access only
// - Words only at even addresses
// - Little-endian: low byte at even address
`timescale 1ns/1ns
`default_nettype none
module mmd_decoder
  import mmd_pkg::*;
#(
  parameter int RAM_BYTES   = RAM_BYTES_DEF,
  parameter int FLASH_BYTES = FLASH_BYTES_DEF
) (
  input  wire logic        clk_sys,       // 100 MHz system clock
  input  wire logic        nrst,          // Async reset, active low
  mmd_bus_if.dev           bus,           // CPU side
  output logic             vec_hit,       // Access fell in vector table
  output logic             cfg_sel,       // Special config byte regs strobe
  output logic             p8_sel,        // 8-bit peripheral strobe
  output logic             p16_sel,       // 16-bit peripheral strobe
  output logic             per_we,        // Peripheral write
  output logic [7:0]       per_addr,      // Peripheral byte address low bits
  output logic [15:0]      per_wdata,     // Peripheral write data
  output logic [1:0]       per_be,        // Peripheral byte enables
  input  wire logic [15:0] per_rdata      // Peripheral read data
);
  localparam logic [16:0] RAM_HI   = 17'(RAM_LO + RAM_BYTES - 1);
  localparam logic [16:0] FLASH_LO = 17'(FLASH_END - FLASH_BYTES + 1);
  localparam logic [16:0] VEC_LO   = 17'(VEC_TOP - 2 * (VEC_WORDS - 1));
  localparam int RAM_WORDS = RAM_BYTES / 2;
  localparam int FL_WORDS  = FLASH_BYTES / 2;
  // From 60 KB up the flash would start at or below 01000h of the 64 KB page
  localparam int FLASH_MAX_BYTES = 61440;

  // Flash index takes low address bits directly, so its size is a power of
  // two; below two words the index slices would turn inside out
  if (RAM_BYTES < 4 || RAM_BYTES % 2 != 0 || FLASH_BYTES < 4 ||
      (FLASH_BYTES & (FLASH_BYTES - 1)) != 0 || FLASH_BYTES >= FLASH_MAX_BYTES ||
      FLASH_LO <= RAM_HI) begin : g_bad_size
    $error("mmd_decoder: memory sizes cannot be served");
  end

  // Region decode, shared by request and answer paths
  function automatic mmd_region_t region_of(input logic [16:0] a);
    if (a <= CFG_HI) region_of = MMD_RG_CFG;
    else if (a >= PER8_LO && a <= PER8_HI) region_of = MMD_RG_PER8;
    else if (a >= PER16_LO && a <= PER16_HI) region_of = MMD_RG_PER16;
    else if (a >= RAM_LO && a <= RAM_HI) region_of = MMD_RG_MEM;
    else if (a >= FLASH_LO && a <= FLASH_END) region_of = MMD_RG_MEM;
    else region_of = MMD_RG_NONE;
  endfunction

  // Byte reads land in the low lane with the high lane cleared
  function automatic logic [15:0] lane_byte(input logic [15:0] w, input logic odd);
    lane_byte = {8'h00, odd ? w[15:8] : w[7:0]};
  endfunction

  logic [15:0] ram   [RAM_WORDS];
  logic [15:0] flash [FL_WORDS];

  // No load port in this block, so flash starts and stays blank
  initial begin
    for (int i = 0; i < FL_WORDS; i++) begin
      flash[i] = FLASH_BLANK;
    end
  end

  typedef struct packed {
    mmd_state_t  st;
    logic        ack;
    logic        err;
    logic [15:0] rdata;
  } mmd_dec_t;

  mmd_dec_t cur;
  mmd_dec_t nxt;

  logic [16:0] a_eff;
  mmd_region_t rg;
  logic        is_ram;
  logic        is_fl;
  logic [15:0] mem_word;
  logic [15:0] wmask;
  logic [15:0] wval;
  logic        go;

  // Word access resolves to enclosing even word
  assign a_eff  = bus.byte_en ? bus.shared_address_bus
                              : {bus.shared_address_bus[16:1], 1'b0};
  assign rg     = region_of(a_eff);
  assign is_ram = (rg == MMD_RG_MEM) && (a_eff <= RAM_HI);
  assign is_fl  = (rg == MMD_RG_MEM) && (a_eff >= FLASH_LO);
  assign go     = bus.req && (cur.st == MMD_ST_IDLE);
  assign vec_hit = go && is_fl && (a_eff >= VEC_LO);

  // Byte lane placement, little-endian
  assign wval  = bus.byte_en ? {2{bus.shared_data_bus_wr[7:0]}}
                             : bus.shared_data_bus_wr;
  assign wmask = !bus.byte_en ? 16'hffff :
                 a_eff[0] ? 16'hff00 : 16'h00ff;

  assign cfg_sel   = go && (rg == MMD_RG_CFG);
  assign p8_sel    = go && (rg == MMD_RG_PER8);
  assign p16_sel   = go && (rg == MMD_RG_PER16);
  assign per_we    = go && bus.we;
  assign per_addr  = a_eff[7:0];
  // 8-bit modules see only the low byte of a word write
  assign per_wdata = (rg == MMD_RG_PER16 && !bus.byte_en) ? bus.shared_data_bus_wr
                     : {8'h00, bus.shared_data_bus_wr[7:0]};
  // Bytes to 16-bit modules sit at even addresses, hence always the low lane
  assign per_be    = (rg == MMD_RG_PER16 && !bus.byte_en) ? 2'b11
                                                          : 2'b01;

  // Offset wraps within the index width; the true RAM index always fits it
  assign mem_word = is_ram ? ram[a_eff[$clog2(RAM_WORDS):1] - RAM_LO[$clog2(RAM_WORDS):1]]
                           : flash[a_eff[$clog2(FL_WORDS):1]];

  // RAM writes; flash is read-only on this port and nothing loads it
  always_ff @(posedge clk_sys) begin
    if (go && bus.we && is_ram) begin
      ram[a_eff[$clog2(RAM_WORDS):1] - RAM_LO[$clog2(RAM_WORDS):1]] <=
        (mem_word & ~wmask) | (wval & wmask);
    end
  end

  always_comb begin
    nxt     = cur;
    nxt.ack = 1'b0;
    case (cur.st)
      MMD_ST_IDLE: begin
        if (bus.req) begin
          nxt.st  = MMD_ST_DONE;
          nxt.ack = 1'b1;
          nxt.err = 1'b0;
          nxt.rdata = ZERO_WORD;
          case (rg)
            MMD_RG_MEM: begin
              if (!bus.we) begin
                if (!bus.byte_en) nxt.rdata = mem_word;
                else nxt.rdata = lane_byte(mem_word, a_eff[0]);
              end
              nxt.err = bus.fetch && bus.shared_address_bus[0];
            end
            MMD_RG_CFG: begin
              if (!bus.we) nxt.rdata = lane_byte(per_rdata, 1'b0);
              nxt.err = !bus.byte_en;
            end
            MMD_RG_PER8: begin
              // High lane of a word read is unspecified; cleared here
              if (!bus.we) nxt.rdata = lane_byte(per_rdata, 1'b0);
            end
            MMD_RG_PER16: begin
              if (!bus.we) begin
                nxt.rdata = bus.byte_en ? lane_byte(per_rdata, 1'b0)
                                        : per_rdata;
              end
              nxt.err = bus.byte_en && a_eff[0];
            end
            default: begin
              // Unclaimed still answers, so the requester never hangs
              nxt.rdata = ZERO_WORD;
            end
          endcase
          // Faults are only flagged; the access still completes
          if (!bus.byte_en && bus.shared_address_bus[0]) nxt.err = 1'b1;
        end
      end
      MMD_ST_DONE: begin
        // Requester drops req after ack; wait so one request is served once
        if (!bus.req) nxt.st = MMD_ST_IDLE;
        else nxt.st = MMD_ST_WAIT;
      end
      MMD_ST_WAIT: begin
        if (!bus.req) nxt.st = MMD_ST_IDLE;
      end
      default: nxt.st = MMD_ST_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      cur <= '{st: MMD_ST_IDLE, ack: 1'b0, err: 1'b0, rdata: ZERO_WORD};
    end else begin
      cur <= nxt;
    end
  end

  assign bus.ack                = cur.ack;
  assign bus.err                = cur.err;
  assign bus.shared_data_bus_rd = cur.rdata;
endmodule
`default_nettype wire

/* File: rtl/mmd_pkg.sv */
// Constants and types shared by both ends of the shared-bus address decoder.
// Assumes a 17-bit byte address (128 KB space) and 16-bit data words.
package mmd_pkg;
  localparam int          ADDR_W        = 17;
  localparam int          DATA_W        = 16;
  localparam logic [16:0] CFG_LO        = 17'h00000;
  localparam logic [16:0] CFG_HI        = 17'h0000f;
  localparam logic [16:0] PER8_LO       = 17'h00010;
  localparam logic [16:0] PER8_HI       = 17'h000ff;
  localparam logic [16:0] PER16_LO      = 17'h00100;
  localparam logic [16:0] PER16_HI      = 17'h001ff;
  localparam logic [16:0] RAM_LO        = 17'h00200;
  localparam logic [16:0] FLASH_END     = 17'h0ffff;
  localparam logic [16:0] VEC_TOP       = 17'h0fffe;
  localparam int          VEC_WORDS     = 16;
  localparam int          RAM_BYTES_DEF = 2048;
  localparam int          FLASH_BYTES_DEF = 32768;
  localparam logic [15:0] ZERO_WORD     = 16'h0000;
  localparam logic [15:0] FLASH_BLANK   = 16'hffff; // Fill of flash nothing has loaded
  localparam int          BYTE_W        = 8;

  typedef enum logic [4:0] {
    MMD_RG_NONE  = 5'h01,
    MMD_RG_CFG   = 5'h02,
    MMD_RG_PER8  = 5'h04,
    MMD_RG_PER16 = 5'h08,
    MMD_RG_MEM   = 5'h10
  } mmd_region_t;

  typedef enum logic [2:0] {
    MMD_ST_IDLE = 3'h1,
    MMD_ST_WAIT = 3'h2,
    MMD_ST_DONE = 3'h4
  } mmd_state_t;
endpackage

/* File: rtl/mmd_requester.sv */
// Requester end: turns user commands, save fetches from config regs, into legal shared-bus accesses.
// Assumes the decoder acks one cycle after req; cmd is latched when accepted, so user need not hold it.
`timescale 1ns/1ns
`default_nettype none
module mmd_requester
  import mmd_pkg::*;
(
  input  wire logic              clk_sys,   // 100 MHz system clock
  input  wire logic              nrst,      // Async reset, active low
  mmd_bus_if.cpu                 bus,       // Decoder side
  input  wire logic              cmd_valid, // Command request
  input  wire logic              cmd_fetch, // Instruction fetch
  input  wire logic              cmd_we,    // Write
  input  wire logic              cmd_byte,  // Byte width
  input  wire logic [ADDR_W-1:0] cmd_addr,  // Byte address
  input  wire logic [DATA_W-1:0] cmd_wdata, // Write data
  output logic                   cmd_ready, // Idle, accepts command
  output logic                   done,      // One-cycle completion pulse
  output logic [DATA_W-1:0]      rdata,     // Read data of last access
  output logic                   rerr       // Last access faulted
);
  typedef struct packed {
    mmd_state_t        st;
    logic              fetch;
    logic              we;
    logic              bw;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic              done;
    logic [DATA_W-1:0] rdata;
    logic              rerr;
  } mmd_req_t;

  mmd_req_t cur;
  mmd_req_t nxt;

  always_comb begin
    nxt      = cur;
    nxt.done = 1'b0;
    case (cur.st)
      MMD_ST_IDLE: begin
        if (cmd_valid) begin
          nxt.st    = MMD_ST_WAIT;
          nxt.fetch = cmd_fetch;
          nxt.we    = cmd_we && !cmd_fetch;
          // Fetches are word wide and even; config reg data accesses get byte access only
          nxt.bw    = !cmd_fetch && (cmd_byte || cmd_addr <= CFG_HI);
          nxt.addr  = (cmd_fetch || !(cmd_byte || cmd_addr <= CFG_HI))
                      ? {cmd_addr[ADDR_W-1:1], 1'b0} : cmd_addr;
          // Byte to a 16-bit module only at its even address
          if (cmd_byte && cmd_addr >= PER16_LO && cmd_addr <= PER16_HI)
            nxt.addr = {cmd_addr[ADDR_W-1:1], 1'b0};
          nxt.wdata = cmd_wdata;
        end
      end
      MMD_ST_WAIT: begin
        if (bus.ack) begin
          nxt.st    = MMD_ST_DONE;
          nxt.done  = 1'b1;
          nxt.rdata = bus.shared_data_bus_rd;
          nxt.rerr  = bus.err;
        end
      end
      MMD_ST_DONE: nxt.st = MMD_ST_IDLE;
      default:     nxt.st = MMD_ST_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      cur <= '{st: MMD_ST_IDLE, fetch: 1'b0, we: 1'b0, bw: 1'b0, addr: '0,
               wdata: ZERO_WORD, done: 1'b0, rdata: ZERO_WORD, rerr: 1'b0};
    end else begin
      cur <= nxt;
    end
  end

  assign bus.req                = (cur.st == MMD_ST_WAIT);
  assign bus.fetch              = cur.fetch;
  assign bus.we                 = cur.we;
  assign bus.byte_en            = cur.bw;
  assign bus.shared_address_bus = cur.addr;
  assign bus.shared_data_bus_wr = cur.wdata;
  assign cmd_ready              = (cur.st == MMD_ST_IDLE);
  assign done                   = cur.done;
  assign rdata                  = cur.rdata;
  assign rerr                   = cur.rerr;
endmodule
`default_nettype wire
